// [design/scsi_map.svh]
// register offsets, field positions, reset values and frame timing of the card channel
`ifndef SCSI_MAP_SVH
`define SCSI_MAP_SVH
// register byte offsets
`define SCSI_OFS_CTRL 8'h00
`define SCSI_OFS_MODE 8'h04
`define SCSI_OFS_CARD 8'h08
`define SCSI_OFS_STAT 8'h0C
`define SCSI_OFS_CLR 8'h10
`define SCSI_OFS_IEN 8'h14
`define SCSI_OFS_TXD 8'h18
`define SCSI_OFS_RXD 8'h1C
// highest mapped word index
`define SCSI_IDX_LAST 6'h07
// serial_control_reg fields
`define SCSI_CTRL_TXEN 0
`define SCSI_CTRL_RXEN 1
`define SCSI_CTRL_CKE 2
`define SCSI_CTRL_CKL 3
`define SCSI_CTRL_RXIRQ 4
// card_mode_reg field: smart card mode select
`define SCSI_CARD_SMIF 0
// status and clear and enable fields
`define SCSI_ST_RXF 0
`define SCSI_ST_PERR 1
`define SCSI_ST_TXD 2
`define SCSI_ST_TXE 3
// reset values
`define SCSI_CTRL_RST 8'h00
`define SCSI_MODE_RST 8'h00
`define SCSI_IEN_RST 4'h0
// bit period in card clock periods and frame positions in bit periods
`define SCSI_ETU_CLKS 372
`define SCSI_ETU_LAST 9'(`SCSI_ETU_CLKS - 1)
`define SCSI_ETU_HALF 9'(`SCSI_ETU_CLKS / 2)
`define SCSI_FRAME_BITS 4'hA
`define SCSI_PAR_BIT 4'h9
`define SCSI_ERR_BIT 4'hA
`define SCSI_RESEND_BIT 4'hD
// bus responses
`define SCSI_RESP_OKAY 2'b00
`define SCSI_RESP_SLVERR 2'b10
`endif

// [design/scsi_pkg.sv]
// state types of the smart card serial channel
package scsi_pkg;
	// receive sequencer states
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_BITS = 2'b01,
		RX_ERRW = 2'b10,
		RX_ERRS = 2'b11
	} scsi_rx_e;
	// transmit sequencer states
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_BITS = 2'b01,
		TX_CHK = 2'b10,
		TX_GAP = 2'b11
	} scsi_tx_e;
endpackage : scsi_pkg

// [design/scsi_sync.sv]
// two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/100ps
module scsi_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// asynchronous in, synchronised out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// first stage, read only by the second
	logic [W-1:0] meta_q;

	// two stages, nothing taps the first
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= '1;
			q <= '1;
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : scsi_sync

// [design/scsi_clkgen.sv]
// card clock generator: whole periods only, stops at a chosen level
`timescale 1ns/100ps
module scsi_clkgen #(
	parameter int HALF = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic en,
	input wire logic level,
	// card clock and period start pulse
	output logic sck_q,
	output logic running_q,
	output logic tick_q
);
	// cycles spent in the current half period
	logic [15:0] cnt_q;
	logic half_end_w;

	assign half_end_w = (cnt_q == 16'(HALF - 1));

	// high half then low half; a stop only lands at the end of the low half
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= 16'h0000;
			sck_q <= 1'b0;
			running_q <= 1'b0;
			tick_q <= 1'b0;
		end
		else
		begin
			tick_q <= 1'b0;
			if (!running_q)
			begin
				cnt_q <= 16'h0000;
				sck_q <= en | level;
				running_q <= en;
				tick_q <= en;
			end
			else if (!half_end_w)
				cnt_q <= cnt_q + 16'h0001;
			else
			begin
				cnt_q <= 16'h0000;
				if (sck_q)
					sck_q <= 1'b0;
				else if (en)
				begin
					sck_q <= 1'b1;
					tick_q <= 1'b1;
				end
				else
				begin
					running_q <= 1'b0;
					sck_q <= level;
				end
			end
		end
	end

	stop_level_a: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(running_q) |-> sck_q == level && $past(sck_q) == 1'b0)
		else $error("card clock did not park after a whole period");
	stop_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
		(running_q && !en) |-> ##[0:8] !running_q)
		else $error("card clock ran on past one period");
	// length of the current high half, restarted whenever the clock is parked
	logic [15:0] hi_len_q;

	// counts high cycles so every high half, the first included, can be measured
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			hi_len_q <= 16'h0000;
		else if (sck_q && running_q)
			hi_len_q <= hi_len_q + 16'h0001;
		else
			hi_len_q <= 16'h0000;
	end

	restart_duty_a: assert property (@(posedge clk) disable iff (!rst_n)
		(running_q && $fell(sck_q)) |-> hi_len_q == 16'(HALF))
		else $error("first card clock period shortened");
endmodule : scsi_clkgen

// [design/scsi_top.sv]
// smart card serial channel: shared data line, card clock, registers over AXI4-Lite
// Notes on behaviour
// - both enables set: own sends are received
// - serial clock pin drives the card clock
// - clock stop finishes period, parks at level
// - restarted clock has normal first period
// - bit is 372 card clocks, frame 10
// - parity failure sets error flag and interrupt
// - no receive-full flag on parity error
// - good parity sets receive-full and interrupt
// - dma read clears receive-full flag
// - good frame: line released in error slot
// - parity error: drive low 1 bit at 10.5
// - card error signal: resend after 2 bits
// - receive interrupt enable gates both receive interrupts
`timescale 1ns/100ps
`include "scsi_map.svh"
module scsi_top
	import scsi_pkg::*;
#(
	parameter int HALF_DIV = 4
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic ARST_N,
	// axi4-lite write
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [7:0] AWADDR,
	input wire logic WVALID,
	output logic WREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	output logic BVALID,
	input wire logic BREADY,
	output logic [1:0] BRESP,
	// axi4-lite read
	input wire logic ARVALID,
	output logic ARREADY,
	input wire logic [7:0] ARADDR,
	output logic RVALID,
	input wire logic RREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	// dma read of the receive data
	input wire logic DMA_RD_STB,
	output logic [7:0] RX_DATA,
	// shared data line, open drain
	input wire logic DATA_IN,
	output logic DATA_OUT,
	output logic DATA_OE_N,
	// card clock pin
	output logic SCK_OUT,
	output logic SCK_OE_N,
	// interrupts
	output logic IRQ,
	output logic RX_FULL_IRQ,
	output logic RX_ERR_IRQ
);
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!ARST_N);

	// next position within a frame: bit index and card clock count
	function automatic logic [12:0] etu_step(input logic [3:0] b, input logic [8:0] c);
		etu_step = (c == `SCSI_ETU_LAST) ? {4'(b + 4'h1), 9'h000} : {b, 9'(c + 9'h001)};
	endfunction : etu_step

	// word-aligned and inside the map
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a[1:0] == 2'b00) && (a[7:2] <= `SCSI_IDX_LAST);
	endfunction : is_mapped

	// bus slave state
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	// software registers
	logic [7:0] ctrl_q, mode_q, card_q, txd_q, rxd_q;
	logic [3:0] ien_q, status_q;
	// sequencers
	scsi_rx_e rx_st_q, rx_st_d;
	scsi_tx_e tx_st_q, tx_st_d;
	logic [8:0] rx_cnt_q, rx_cnt_d, tx_cnt_q, tx_cnt_d;
	logic [3:0] rx_bit_q, rx_bit_d, tx_bit_q, tx_bit_d;
	logic [7:0] rx_sh_q, rx_sh_d;
	logic [9:0] tx_frame_q;
	logic tx_pend_q;
	// pins and interrupts
	logic oe_n_q, loop_q, line_prev_q, sck_oe_n_q, irq_q, rxf_irq_q, rxe_irq_q;
	logic line_s_w, sck_w, run_w, tick_w;

	// data line into the clock domain
	scsi_sync #(.W(1)) u_sync (
		.clk(REF_CLK),
		.rst_n(ARST_N),
		.d(DATA_IN),
		.q(line_s_w)
	);

	// card clock source
	scsi_clkgen #(.HALF(HALF_DIV)) u_clk (
		.clk(REF_CLK),
		.rst_n(ARST_N),
		.en(ctrl_q[`SCSI_CTRL_CKE]),
		.level(ctrl_q[`SCSI_CTRL_CKL]),
		.sck_q(sck_w),
		.running_q(run_w),
		.tick_q(tick_w)
	);

	// control decode
	logic tx_en_w, rx_en_w, rx_irq_en_w;
	assign tx_en_w = ctrl_q[`SCSI_CTRL_TXEN];
	assign rx_en_w = ctrl_q[`SCSI_CTRL_RXEN];
	assign rx_irq_en_w = ctrl_q[`SCSI_CTRL_RXIRQ];

	// write decode: both halves held and no response pending
	logic wr_fire_w, wr_b0_w;
	logic [3:0] clr_w;
	assign wr_fire_w = !awready_q && !wready_q && !bvalid_q;
	assign wr_b0_w = wr_fire_w && wstrb_q[0];
	assign clr_w = (wr_b0_w && awaddr_q == `SCSI_OFS_CLR) ? wdata_q[3:0] : 4'h0;

	// read selection
	logic [31:0] rd_w;
	assign rd_w = (ARADDR == `SCSI_OFS_CTRL) ? {24'h00_0000, ctrl_q} :
		(ARADDR == `SCSI_OFS_MODE) ? {24'h00_0000, mode_q} :
		(ARADDR == `SCSI_OFS_CARD) ? {24'h00_0000, card_q} :
		(ARADDR == `SCSI_OFS_STAT) ? {28'h000_0000, status_q} :
		(ARADDR == `SCSI_OFS_IEN) ? {28'h000_0000, ien_q} :
		(ARADDR == `SCSI_OFS_TXD) ? {24'h00_0000, txd_q} :
		(ARADDR == `SCSI_OFS_RXD) ? {24'h00_0000, rxd_q} : 32'h0000_0000;

	// write channel: take address and data in either order
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= `SCSI_RESP_OKAY;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end
		else
		begin
			if (AWVALID && awready_q)
			begin
				awaddr_q <= AWADDR;
				awready_q <= 1'b0;
			end
			if (WVALID && wready_q)
			begin
				wdata_q <= WDATA;
				wstrb_q <= WSTRB;
				wready_q <= 1'b0;
			end
			if (wr_fire_w)
			begin
				bvalid_q <= 1'b1;
				bresp_q <= is_mapped(awaddr_q) ? `SCSI_RESP_OKAY : `SCSI_RESP_SLVERR;
			end
			else if (bvalid_q && BREADY)
			begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// read channel: one cycle to data
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `SCSI_RESP_OKAY;
		end
		else if (ARVALID && arready_q)
		begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_w;
			rresp_q <= is_mapped(ARADDR) ? `SCSI_RESP_OKAY : `SCSI_RESP_SLVERR;
		end
		else if (rvalid_q && RREADY)
		begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// software registers, low byte lane only
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			ctrl_q <= `SCSI_CTRL_RST;
			mode_q <= `SCSI_MODE_RST;
			card_q <= `SCSI_MODE_RST;
			ien_q <= `SCSI_IEN_RST;
			txd_q <= `SCSI_MODE_RST;
		end
		else if (wr_b0_w)
		begin
			if (awaddr_q == `SCSI_OFS_CTRL)
				ctrl_q <= wdata_q[7:0];
			if (awaddr_q == `SCSI_OFS_MODE)
				mode_q <= wdata_q[7:0];
			if (awaddr_q == `SCSI_OFS_CARD)
				card_q <= wdata_q[7:0];
			if (awaddr_q == `SCSI_OFS_IEN)
				ien_q <= wdata_q[3:0];
			if (awaddr_q == `SCSI_OFS_TXD)
				txd_q <= wdata_q[7:0];
		end
	end

	// receive line: own drive folded in so loop-back needs no card
	logic rx_line_w, rx_fall_w, rx_mid_w, par_eval_w, par_bad_w, rx_set_w, rx_perr_w;
	assign rx_line_w = line_s_w & loop_q;
	assign rx_fall_w = line_prev_q && !rx_line_w;
	assign rx_mid_w = tick_w && rx_cnt_q == `SCSI_ETU_HALF;
	assign par_eval_w = rx_st_q == RX_BITS && rx_mid_w && rx_bit_q == `SCSI_PAR_BIT;
	assign par_bad_w = ^{rx_line_w, rx_sh_q};
	assign rx_set_w = par_eval_w && !par_bad_w;
	assign rx_perr_w = par_eval_w && par_bad_w;

	// receive sequencer next state
	always_comb
	begin
		rx_st_d = rx_st_q;
		rx_sh_d = rx_sh_q;
		{rx_bit_d, rx_cnt_d} = {rx_bit_q, rx_cnt_q};
		if (rx_st_q != RX_IDLE && tick_w)
			{rx_bit_d, rx_cnt_d} = etu_step(rx_bit_q, rx_cnt_q);
		case (rx_st_q)
			RX_IDLE:
				if (rx_fall_w)
				begin
					rx_st_d = RX_BITS;
					{rx_bit_d, rx_cnt_d} = 13'h0000;
				end
			RX_BITS:
				if (rx_mid_w)
				begin
					// false start, or parity decides the error slot
					if (rx_bit_q == 4'h0 && rx_line_w)
						rx_st_d = RX_IDLE;
					else if (rx_bit_q == `SCSI_PAR_BIT)
						rx_st_d = par_bad_w ? RX_ERRW : RX_IDLE;
					else if (rx_bit_q != 4'h0)
						rx_sh_d = {rx_line_w, rx_sh_q[7:1]};
				end
			RX_ERRW:
				if (rx_mid_w && rx_bit_q == `SCSI_ERR_BIT)
					rx_st_d = RX_ERRS;
			RX_ERRS:
				if (rx_mid_w && rx_bit_q == 4'(`SCSI_ERR_BIT + 4'h1))
					rx_st_d = RX_IDLE;
			default:
				rx_st_d = RX_IDLE;
		endcase
		if (!rx_en_w)
			rx_st_d = RX_IDLE;
	end

	// transmit decode
	logic tx_go_w, tx_chk_w, tx_low_w;
	assign tx_go_w = tx_en_w && tx_pend_q && run_w && tick_w;
	assign tx_chk_w = tick_w && tx_bit_q == `SCSI_ERR_BIT && tx_cnt_q == `SCSI_ETU_LAST;
	// only a low level is driven
	assign tx_low_w = tx_st_q == TX_BITS && tx_bit_q < `SCSI_FRAME_BITS && !tx_frame_q[tx_bit_q];

	// transmit sequencer next state
	always_comb
	begin
		tx_st_d = tx_st_q;
		{tx_bit_d, tx_cnt_d} = {tx_bit_q, tx_cnt_q};
		if (tx_st_q != TX_IDLE && tick_w)
			{tx_bit_d, tx_cnt_d} = etu_step(tx_bit_q, tx_cnt_q);
		case (tx_st_q)
			TX_IDLE:
				if (tx_go_w)
				begin
					tx_st_d = TX_BITS;
					{tx_bit_d, tx_cnt_d} = 13'h0000;
				end
			TX_BITS:
				if (tx_bit_q == `SCSI_FRAME_BITS)
					tx_st_d = TX_CHK;
			TX_CHK:
				if (tx_chk_w)
					tx_st_d = TX_GAP;
			TX_GAP:
				// resend no sooner than 2 bits
				if (tx_bit_q == `SCSI_RESEND_BIT)
					tx_st_d = TX_IDLE;
			default:
				tx_st_d = TX_IDLE;
		endcase
		if (!tx_en_w)
			tx_st_d = TX_IDLE;
	end

	// sequencer registers and receive data
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			rx_st_q <= RX_IDLE;
			tx_st_q <= TX_IDLE;
			{rx_bit_q, rx_cnt_q, tx_bit_q, tx_cnt_q} <= 26'h000_0000;
			rx_sh_q <= 8'h00;
			rxd_q <= 8'h00;
		end
		else
		begin
			rx_st_q <= rx_st_d;
			tx_st_q <= tx_st_d;
			{rx_bit_q, rx_cnt_q, tx_bit_q, tx_cnt_q} <= {rx_bit_d, rx_cnt_d, tx_bit_d, tx_cnt_d};
			rx_sh_q <= rx_sh_d;
			if (rx_set_w)
				rxd_q <= rx_sh_q;
		end
	end

	// pending character: loaded by a data write, kept until the card accepts it or transmit is disabled
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			tx_pend_q <= 1'b0;
			tx_frame_q <= 10'h3FF;
		end
		else if (wr_b0_w && awaddr_q == `SCSI_OFS_TXD && tx_en_w)
		begin
			tx_pend_q <= 1'b1;
			tx_frame_q <= {^wdata_q[7:0], wdata_q[7:0], 1'b0};
		end
		else if (!tx_en_w || (tx_chk_w && tx_st_q == TX_CHK && rx_line_w))
			tx_pend_q <= 1'b0;
	end

	// sticky status: a set in the clearing cycle wins
	logic [3:0] st_set_w, st_clr_w;
	assign st_set_w = {tx_chk_w && tx_st_q == TX_CHK && !rx_line_w,
		tx_chk_w && tx_st_q == TX_CHK && rx_line_w, rx_perr_w, rx_set_w};
	assign st_clr_w = {clr_w[3:1], clr_w[0] | DMA_RD_STB};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_status
			always_ff @(posedge REF_CLK or negedge ARST_N)
			begin
				if (!ARST_N)
					status_q[gi] <= 1'b0;
				else if (st_set_w[gi])
					status_q[gi] <= 1'b1;
				else if (st_clr_w[gi])
					status_q[gi] <= 1'b0;
			end
		end
	endgenerate

	// pin drivers and interrupt outputs
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			oe_n_q <= 1'b1;
			loop_q <= 1'b1;
			line_prev_q <= 1'b1;
			sck_oe_n_q <= 1'b1;
			{irq_q, rxf_irq_q, rxe_irq_q} <= 3'h0;
		end
		else
		begin
			oe_n_q <= !(tx_low_w || rx_st_q == RX_ERRS);
			loop_q <= oe_n_q;
			line_prev_q <= rx_line_w;
			sck_oe_n_q <= !(card_q[`SCSI_CARD_SMIF] || ctrl_q[`SCSI_CTRL_CKE]);
			irq_q <= |(status_q & ien_q);
			rxf_irq_q <= status_q[`SCSI_ST_RXF] & rx_irq_en_w;
			rxe_irq_q <= status_q[`SCSI_ST_PERR] & rx_irq_en_w;
		end
	end

	// port drive
	assign {AWREADY, WREADY, BVALID, BRESP} = {awready_q, wready_q, bvalid_q, bresp_q};
	assign {ARREADY, RVALID, RDATA, RRESP} = {arready_q, rvalid_q, rdata_q, rresp_q};
	assign RX_DATA = rxd_q;
	assign DATA_OUT = 1'b0;
	assign DATA_OE_N = oe_n_q;
	assign SCK_OUT = sck_w;
	assign SCK_OE_N = sck_oe_n_q;
	assign {IRQ, RX_FULL_IRQ, RX_ERR_IRQ} = {irq_q, rxf_irq_q, rxe_irq_q};

	loop_back_a: assert property ((!oe_n_q) |=> !rx_line_w)
		else $error("own low level not seen by receiver");
	par_err_a: assert property (rx_perr_w |=> status_q[`SCSI_ST_PERR] ##1 rxe_irq_q == rx_irq_en_w)
		else $error("parity error not flagged");
	no_full_a: assert property ((rx_perr_w && !status_q[0]) |=> !status_q[0])
		else $error("receive full set on bad frame");
	rx_ok_a: assert property ((rx_set_w && !status_q[1]) |=> status_q[0] && !status_q[1])
		else $error("good frame not flagged full");
	dma_clear_a: assert property ((DMA_RD_STB && !rx_set_w) |=> !status_q[`SCSI_ST_RXF])
		else $error("dma read left full flag");
	ok_release_a: assert property (rx_set_w |=> (rx_st_q != RX_ERRS) [*8])
		else $error("line driven after good frame");
	err_slot_a: assert property ((rx_st_q == RX_ERRS) |->
		(rx_bit_q == `SCSI_ERR_BIT) || (rx_bit_q == 4'hB && rx_cnt_q <= `SCSI_ETU_HALF))
		else $error("error signal outside its slot");
	resend_gap_a: assert property ((tx_st_q == TX_GAP && tx_st_d == TX_IDLE && tx_en_w) |->
		tx_bit_q >= `SCSI_RESEND_BIT)
		else $error("resend too early");
	irq_gate_a: assert property ((!rx_irq_en_w) |=> !RX_FULL_IRQ && !RX_ERR_IRQ)
		else $error("receive interrupt not gated");
	frame_len_a: assert property ((tx_st_q != TX_IDLE) |-> tx_cnt_q <= `SCSI_ETU_LAST)
		else $error("bit period overrun");
	drive_low_a: assert property ((!DATA_OE_N) |-> DATA_OUT == 1'b0)
		else $error("data line driven high");
	rx_good_c: cover property (rx_set_w);
	rx_bad_c: cover property (rx_st_q == RX_ERRS);
	tx_resend_c: cover property (tx_st_q == TX_GAP && tx_pend_q ##1 tx_st_q == TX_IDLE);
	clk_stop_c: cover property ($fell(run_w));
endmodule : scsi_top

// [testbench/scsi_card.sv]
// behavioural smart card on the shared data line, clocked by the card clock pin
`timescale 1ns/100ps
`include "scsi_map.svh"
module scsi_card (
	// card clock and line level
	input wire logic sck,
	input wire logic line,
	// reject every other frame while set
	input wire logic nack_en,
	// pull on the line and what the card saw
	output logic pull_q,
	output int rx_cnt,
	output logic [7:0] rx_byte,
	output logic err_seen
);
	// bit period in card clocks
	localparam int ETU = `SCSI_ETU_CLKS;
	// set while the card itself sends
	logic busy;
	// the last frame was rejected
	logic nacked;

	// idle card: line released
	initial
	begin
		pull_q = 1'b0;
		rx_cnt = 0;
		rx_byte = 8'h00;
		err_seen = 1'b0;
		busy = 1'b0;
		nacked = 1'b0;
	end

	// receive a frame, lsb first, sampled mid bit, even parity
	always
	begin : rx
		logic [8:0] sh;
		@(negedge line);
		if (!busy)
		begin
			repeat (ETU / 2) @(posedge sck);
			for (int i = 0; i < 9; i++)
			begin
				repeat (ETU) @(posedge sck);
				sh[i] = line;
			end
			repeat (ETU) @(posedge sck);
			if ((^sh) || (nack_en && !nacked))
			begin
				pull_q = 1'b1;
				nacked = 1'b1;
				repeat (ETU) @(posedge sck);
				pull_q = 1'b0;
			end
			else
			begin
				nacked = 1'b0;
				rx_byte = sh[7:0];
				rx_cnt++;
			end
		end
	end

	// send one character; bad flips the parity bit
	task automatic send(input logic [7:0] b, input logic bad);
		logic [9:0] fr;
		fr = {(^b) ^ bad, b, 1'b0};
		busy = 1'b1;
		for (int i = 0; i < 10; i++)
		begin
			pull_q = !fr[i];
			repeat (ETU) @(posedge sck);
		end
		pull_q = 1'b0;
		repeat (ETU) @(posedge sck);
		// the channel's error signal is looked for mid slot
		err_seen = !line;
		repeat (ETU) @(posedge sck);
		busy = 1'b0;
	endtask : send
endmodule : scsi_card

// [testbench/smart_card_serial_interface_bench.sv]
// self-checking bench of the smart card channel with a card on the shared line
`timescale 1ns/100ps
`include "scsi_map.svh"
module smart_card_serial_interface_bench;
	// card clock half period in system clocks, short for run time
	localparam int HALF = 1;
	localparam int BIT = `SCSI_ETU_CLKS * 2 * HALF;
	// design pins
	logic REF_CLK, ARST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, DMA_RD_STB;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, DATA_OUT, DATA_OE_N;
	logic SCK_OUT, SCK_OE_N, IRQ, RX_FULL_IRQ, RX_ERR_IRQ;
	logic [7:0] AWADDR, ARADDR, RX_DATA;
	logic [31:0] WDATA, RDATA;
	logic [3:0] WSTRB;
	logic [1:0] BRESP, RRESP;
	// card side and bench state
	logic card_pull, nack_en, card_err;
	logic [7:0] card_byte, b1, b2;
	logic [31:0] lfsr_q;
	int card_cnt, err_total, check_count, n, c0;
	logic [33:0] exp_q[$];
	// pulled-up line: low while either party pulls
	wire line_w = ((!DATA_OE_N && !DATA_OUT) || card_pull) ? 1'b0 : 1'b1;

	scsi_top #(.HALF_DIV(HALF)) i_dut (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR), .WVALID(WVALID),
		.WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB), .BVALID(BVALID), .BREADY(BREADY),
		.BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
		.RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
		.DMA_RD_STB(DMA_RD_STB), .RX_DATA(RX_DATA), .DATA_IN(line_w), .DATA_OUT(DATA_OUT),
		.DATA_OE_N(DATA_OE_N), .SCK_OUT(SCK_OUT), .SCK_OE_N(SCK_OE_N), .IRQ(IRQ),
		.RX_FULL_IRQ(RX_FULL_IRQ), .RX_ERR_IRQ(RX_ERR_IRQ));
	scsi_card i_card (.sck(SCK_OUT), .line(line_w), .nack_en(nack_en), .pull_q(card_pull),
		.rx_cnt(card_cnt), .rx_byte(card_byte), .err_seen(card_err));

	// system clock, 100 ns
	initial
	begin
		REF_CLK = 1'b0;
		forever #50 REF_CLK = ~REF_CLK;
	end

	// next pseudo-random word
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// compare any value and count it
	task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	// compare one pin level
	task automatic pin(input logic got, input logic exp);
		cmp({33'h0, got}, {33'h0, exp});
	endtask : pin

	task automatic cyc(input int k);
		repeat (k) @(posedge REF_CLK);
	endtask : cyc

	// wait while s differs from v, then count cycles that it equals v
	task automatic span(ref logic s, input logic v, output int k);
		for (int i = 0; i < 3000 && s !== v; i++) @(posedge REF_CLK);
		for (k = 0; k < 3000 && s === v; k++) @(posedge REF_CLK);
	endtask : span

	// bus write; the response is noted for the watcher
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic pa, pw;
		exp_q.push_back({r, 32'h0});
		@(posedge REF_CLK);
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		AWADDR <= a;
		WDATA <= d;
		BREADY <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		while (pa || pw)
		begin
			@(posedge REF_CLK);
			pa = pa && !AWREADY;
			pw = pw && !WREADY;
			AWVALID <= pa;
			WVALID <= pw;
		end
		while (!BVALID) @(posedge REF_CLK);
		BREADY <= 1'b0;
	endtask : wr

	// bus read; the expected answer is noted for the watcher
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		@(posedge REF_CLK);
		ARVALID <= 1'b1;
		ARADDR <= a;
		RREADY <= 1'b1;
		do @(posedge REF_CLK); while (!ARREADY);
		ARVALID <= 1'b0;
		while (!RVALID) @(posedge REF_CLK);
		RREADY <= 1'b0;
	endtask : rd

	// watcher: each taken answer is held against the oldest note
	always @(posedge REF_CLK)
	begin
		if (BVALID && BREADY)
			cmp({BRESP, 32'h0}, exp_q.pop_front());
		if (RVALID && RREADY)
			cmp({RRESP, RDATA}, exp_q.pop_front());
	end

	// verdict and end of run
	task automatic finish_test;
		if (err_total == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test

	// hang guard, well beyond the planned traffic
	initial
	begin
		cyc(90000);
		err_total++;
		finish_test();
	end

	// main sequence
	initial
	begin
		{AWVALID, WVALID, BREADY, ARVALID, RREADY, DMA_RD_STB, nack_en} = 7'h00;
		{AWADDR, ARADDR, WDATA} = 48'h0;
		WSTRB = 4'hF;
		ARST_N = 1'b0;
		err_total = 0;
		check_count = 0;
		lfsr_q = 32'h41e0;
		cyc(5);
		ARST_N <= 1'b1;
		// reset values and an unmapped place
		rd(`SCSI_OFS_CTRL, 34'h0);
		rd(`SCSI_OFS_STAT, 34'h0);
		rd(8'h20, {`SCSI_RESP_SLVERR, 32'h0});
		wr(8'h20, 32'h1, `SCSI_RESP_SLVERR);
		pin(SCK_OE_N, 1'b1);
		// power-on: level, then card mode, then clock
		wr(`SCSI_OFS_CTRL, 32'h08, 2'b00);
		wr(`SCSI_OFS_CARD, 32'h01, 2'b00);
		cyc(2);
		pin(SCK_OUT, 1'b1);
		wr(`SCSI_OFS_IEN, 32'h3, 2'b00);
		wr(`SCSI_OFS_CTRL, 32'h1F, 2'b00);
		pin(SCK_OE_N, 1'b0);
		// loop-back of a random character with its first bit set
		lfsr_q = lfsr(lfsr_q);
		b1 = lfsr_q[7:0] | 8'h01;
		wr(`SCSI_OFS_TXD, {24'h0, b1}, 2'b00);
		span(DATA_OE_N, 1'b0, n);
		cmp(34'(n), 34'(BIT));
		pin(DATA_OUT, 1'b0);
		for (int i = 0; i < 12 * BIT && !RX_FULL_IRQ; i++) @(posedge REF_CLK);
		cmp({26'h0, RX_DATA}, {26'h0, b1});
		cyc(3 * BIT);
		pin(IRQ, 1'b1);
		rd(`SCSI_OFS_STAT, 34'h5);
		rd(`SCSI_OFS_RXD, {26'h0, b1});
		DMA_RD_STB <= 1'b1;
		cyc(1);
		DMA_RD_STB <= 1'b0;
		cyc(3);
		pin(RX_FULL_IRQ, 1'b0);
		wr(`SCSI_OFS_CLR, 32'hF, 2'b00);
		// card rejects the first send; the same character follows
		lfsr_q = lfsr(lfsr_q);
		b2 = lfsr_q[7:0];
		c0 = card_cnt;
		nack_en <= 1'b1;
		wr(`SCSI_OFS_CTRL, 32'h1D, 2'b00);
		wr(`SCSI_OFS_TXD, {24'h0, b2}, 2'b00);
		for (int i = 0; i < 30 * BIT && card_cnt == c0; i++) @(posedge REF_CLK);
		cmp({26'h0, card_byte}, {26'h0, b2});
		nack_en <= 1'b0;
		cyc(2 * BIT);
		rd(`SCSI_OFS_STAT, 34'hC);
		wr(`SCSI_OFS_CLR, 32'hF, 2'b00);
		// card sends bad parity: error slot, flag, no full flag
		wr(`SCSI_OFS_CTRL, 32'h1F, 2'b00);
		i_card.send(lfsr_q[15:8], 1'b1);
		pin(card_err, 1'b1);
		pin(RX_ERR_IRQ, 1'b1);
		rd(`SCSI_OFS_STAT, 34'h2);
		wr(`SCSI_OFS_CTRL, 32'h0F, 2'b00);
		cyc(2);
		pin(RX_ERR_IRQ, 1'b0);
		pin(IRQ, 1'b1);
		wr(`SCSI_OFS_CLR, 32'h2, 2'b00);
		cyc(2);
		pin(IRQ, 1'b0);
		// good character from the card with receive interrupts off
		i_card.send(lfsr_q[23:16], 1'b0);
		pin(card_err, 1'b0);
		pin(RX_FULL_IRQ, 1'b0);
		pin(IRQ, 1'b1);
		rd(`SCSI_OFS_RXD, {26'h0, lfsr_q[23:16]});
		// standby order: level low, stop, clear modes
		wr(`SCSI_OFS_CTRL, 32'h04, 2'b00);
		wr(`SCSI_OFS_CTRL, 32'h00, 2'b00);
		cyc(2 * HALF + 2);
		wr(`SCSI_OFS_MODE, 32'h00, 2'b00);
		wr(`SCSI_OFS_CARD, 32'h00, 2'b00);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge REF_CLK);
			pin(SCK_OUT, 1'b0);
		end
		// restart: mode, then clock with level low; first period full
		wr(`SCSI_OFS_CARD, 32'h01, 2'b00);
		wr(`SCSI_OFS_CTRL, 32'h04, 2'b00);
		span(SCK_OUT, 1'b1, n);
		cmp(34'(n), 34'(HALF));
		span(SCK_OUT, 1'b0, n);
		cmp(34'(n), 34'(HALF));
		finish_test();
	end
endmodule : smart_card_serial_interface_bench
